// ### src/pcr_pkg.sv
/*
 * package for the configuration register group: command codes, field layouts,
 * register addresses of the controller side and timing constants.
 * assumes one 40 MHz clock shared by both ends.
 */
package pcr_pkg;
	// command codes carried on the link
	localparam logic [7:0] CMD_SILICON_REV = 8'hAE;
	localparam logic [7:0] CMD_LOOP_COMP = 8'hB1;
	localparam logic [7:0] CMD_POWER_STAGE = 8'hB5;
	localparam logic [7:0] CMD_STORE_ALL = 8'h15;
	localparam logic [7:0] CMD_RESTORE_ALL = 8'h16;
	localparam logic [7:0] CMD_PIN_OVERRIDE = 8'hEE;
	// byte counts of the block transfers
	localparam logic [2:0] LEN_SILICON_REV = 3'h2;
	localparam logic [2:0] LEN_LOOP_COMP = 3'h5;
	localparam logic [2:0] LEN_POWER_STAGE = 3'h1;
	// revision fields, values arbitrary
	localparam logic [3:0] REV_MAJOR_VAL = 4'h1;
	localparam logic [3:0] REV_MINOR_VAL = 4'h2;
	localparam logic [7:0] REV_SUB_VAL = 8'h03;
	// compensation word field positions
	localparam int CIC_LO_MSB = 25;
	localparam int CIC_LO_LSB = 24;
	localparam int CIC_HI_MSB = 39;
	localparam int CIC_HI_LSB = 38;
	localparam int CFC_MSB = 37;
	localparam int CFC_LSB = 33;
	localparam int CDBL_BIT = 32;
	localparam int CGR_MSB = 31;
	localparam int CGR_LSB = 26;
	localparam int VIC_LO_MSB = 9;
	localparam int VIC_LO_LSB = 8;
	localparam int VIC_HI_MSB = 23;
	localparam int VIC_HI_LSB = 22;
	localparam int VFC_MSB = 21;
	localparam int VFC_LSB = 17;
	localparam int VGR_MSB = 15;
	localparam int VGR_LSB = 10;
	localparam int VTC_MSB = 5;
	localparam int VTC_LSB = 4;
	localparam int CTC_MSB = 1;
	localparam int CTC_LSB = 0;
	// reserved compensation bits must be zero
	localparam logic [39:0] COMP_RSVD_MASK = 40'h00000100CC;
	// power stage byte
	localparam logic [3:0] REG_SEL_MIN = 4'h3;
	localparam logic [3:0] REG_SEL_MAX = 4'hA;
	localparam logic [3:0] REG_SEL_RESET = 4'h9;
	localparam logic [3:0] PS_RSVD_VAL = 4'h0;
	localparam logic [39:0] COMP_RESET = 40'h0000000000;
	// status bits
	localparam int STATUS_CML_BIT = 1;
	localparam int INVALID_COMMAND_FLAG_BIT = 7;
	// time limit on a power stage transaction; neither end uses PS_LIMIT_CYC, so no frame is timed out
	localparam int PS_LIMIT_US = 1000;
	localparam int CLK_MHZ = 40;
	localparam int PS_LIMIT_CYC = PS_LIMIT_US * CLK_MHZ;
	// controller register addresses
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_COMP_LO = 4'h1;
	localparam logic [3:0] A_COMP_HI = 4'h2;
	localparam logic [3:0] A_PS = 4'h3;
	localparam logic [3:0] A_RDATA_LO = 4'h4;
	localparam logic [3:0] A_RDATA_HI = 4'h5;
	localparam logic [3:0] A_STAT = 4'h6;
	localparam logic [3:0] A_IRQ = 4'h7;
	localparam logic [3:0] A_MASK = 4'h8;
	// ctrl register operation codes
	localparam logic [2:0] OP_RD_REV = 3'h0;
	localparam logic [2:0] OP_RD_COMP = 3'h1;
	localparam logic [2:0] OP_WR_COMP = 3'h2;
	localparam logic [2:0] OP_RD_PS = 3'h3;
	localparam logic [2:0] OP_WR_PS = 3'h4;
	localparam logic [2:0] OP_WR_REV = 3'h5;
	localparam logic [2:0] OP_APPLY = 3'h6;
	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ALERT = 1;
	localparam int IRQ_W = 2;
endpackage : pcr_pkg

// ### src/pcr_link_if.sv
/*
 * byte link between controller and device: one command per frame, bytes move
 * one per valid cycle; device answers reads with bytes on the return lane.
 * assumes both ends share core_clk.
 */
`timescale 1ns/1ps
interface pcr_link_if;
	logic start;       // first cycle of a frame, carries command
	logic is_write;
	logic [7:0] cmd;
	logic [2:0] len;   // byte count the controller sends or wants
	logic wvalid;
	logic [7:0] wdata;
	logic rvalid;
	logic [7:0] rdata;
	logic done;        // frame finished by device
	logic alert_n;     // fault notification, active low
	logic store_all;   // save user values pulse
	logic restore_all; // restore user values pulse
	logic clear_comp_override;
	modport device (input start, is_write, cmd, len, wvalid, wdata, store_all,
		restore_all, clear_comp_override, output rvalid, rdata, done, alert_n);
	modport host (output start, is_write, cmd, len, wvalid, wdata, store_all,
		restore_all, clear_comp_override, input rvalid, rdata, done, alert_n);
endinterface : pcr_link_if

// ### src/pcr_device.sv
/*
 * device end: revision, compensation and power stage registers with fault
 * logging for writes to read-only commands.
 * assumes the controller end keeps to one frame at a time.
 */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module pcr_device
	import pcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	pcr_link_if.device link,
	input wire logic conversion_en,
	input wire logic clear_faults,
	output logic [39:0] loop_comp_hw,
	output logic [3:0] current_integ_cap_sel,
	output logic [4:0] current_filter_cap_sel,
	output logic current_integ_cap_doubler,
	output logic [5:0] current_gain_res_sel,
	output logic [3:0] voltage_integ_cap_sel,
	output logic [4:0] voltage_filter_cap_sel,
	output logic [5:0] voltage_gain_res_sel,
	output logic [1:0] voltage_transcond_sel,
	output logic [1:0] current_transcond_sel,
	output logic [3:0] regulator_voltage_sel,
	output logic [7:0] status_byte,
	output logic [7:0] status_comm
);
	typedef enum logic [2:0] {
		DS_IDLE = 3'b001,
		DS_RX = 3'b010,
		DS_TX = 3'b100
	} pcr_dstate_t;

	pcr_dstate_t state_reg;
	logic [7:0] cmd_reg;
	logic [2:0] cnt_reg;
	logic [39:0] shift_reg;
	logic [39:0] comp_reg;
	logic comp_override_reg;
	logic [3:0] reg_sel_reg;
	logic invalid_command_flag;
	logic ivc_event;
	logic rx_last;

	// revision word packs major, minor and sub fields
	function automatic logic [15:0] rev_word();
		logic [3:0] rev_major_field;
		logic [3:0] rev_minor_field;
		logic [7:0] rev_sub_field;
		rev_major_field = REV_MAJOR_VAL;
		rev_minor_field = REV_MINOR_VAL;
		rev_sub_field = REV_SUB_VAL;
		return {rev_major_field, rev_minor_field, rev_sub_field};
	endfunction : rev_word

	assign ivc_event = link.start && link.is_write && (link.cmd == CMD_SILICON_REV);
	assign rx_last = link.wvalid && (cnt_reg == 3'h1);

	// frame sequencer: collect write bytes or shift out read bytes, low byte first
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= DS_IDLE;
			cmd_reg <= 8'h00;
			cnt_reg <= 3'h0;
			shift_reg <= 40'h0000000000;
			link.rvalid <= 1'b0;
			link.rdata <= 8'h00;
			link.done <= 1'b0;
		end else if (clk_en) begin
			link.done <= 1'b0;
			link.rvalid <= 1'b0;
			case (state_reg)
				DS_IDLE: begin
					if (link.start) begin
						cmd_reg <= link.cmd;
						cnt_reg <= link.len;
						if (link.is_write) begin
							state_reg <= DS_RX;
						end else begin
							state_reg <= DS_TX;
							if (link.cmd == CMD_SILICON_REV) begin
								shift_reg <= {24'h000000, rev_word()};
								cnt_reg <= LEN_SILICON_REV;
							end else if (link.cmd == CMD_LOOP_COMP) begin
								shift_reg <= comp_reg;
								cnt_reg <= LEN_LOOP_COMP;
							end else begin
								shift_reg <= {32'h00000000, reg_sel_reg, PS_RSVD_VAL};
								cnt_reg <= LEN_POWER_STAGE;
							end
						end
					end
				end
				DS_RX: begin
					if (link.wvalid) begin
						shift_reg <= {link.wdata, shift_reg[39:8]};
						cnt_reg <= cnt_reg - 3'h1;
					end
					if (rx_last || cnt_reg == 3'h0) begin
						state_reg <= DS_IDLE;
						link.done <= 1'b1;
					end
				end
				DS_TX: begin
					link.rvalid <= 1'b1;
					link.rdata <= shift_reg[7:0];
					shift_reg <= {8'h00, shift_reg[39:8]};
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1) begin
						state_reg <= DS_IDLE;
						link.done <= 1'b1;
					end
				end
				default: state_reg <= DS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			comp_reg <= COMP_RESET;
		end else if (clk_en && state_reg == DS_RX && rx_last && cmd_reg == CMD_LOOP_COMP) begin
			comp_reg <= {link.wdata, shift_reg[39:8]};
		end
	end

	// override bit decides whether restore reloads the loop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			comp_override_reg <= 1'b1;
		end else if (clk_en && link.clear_comp_override) begin
			comp_override_reg <= 1'b0;
		end
	end

	// hardware copy frozen while converting, restore applies stored value once the override bit is cleared
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			loop_comp_hw <= COMP_RESET;
		end else if (clk_en) begin
			if (!conversion_en) begin
				loop_comp_hw <= comp_reg;
			end else if (link.restore_all && !comp_override_reg) begin
				loop_comp_hw <= comp_reg;
			end
		end
	end

	// field taps of the applied compensation word, registered
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			current_integ_cap_sel <= 4'h0;
			current_filter_cap_sel <= 5'h00;
			current_integ_cap_doubler <= 1'b0;
			current_gain_res_sel <= 6'h00;
			voltage_integ_cap_sel <= 4'h0;
			voltage_filter_cap_sel <= 5'h00;
			voltage_gain_res_sel <= 6'h00;
			voltage_transcond_sel <= 2'h0;
			current_transcond_sel <= 2'h0;
		end else if (clk_en) begin
			current_integ_cap_sel <= {loop_comp_hw[CIC_LO_MSB:CIC_LO_LSB],
				loop_comp_hw[CIC_HI_MSB:CIC_HI_LSB]};
			current_filter_cap_sel <= loop_comp_hw[CFC_MSB:CFC_LSB];
			current_gain_res_sel <= loop_comp_hw[CGR_MSB:CGR_LSB];
			current_integ_cap_doubler <= loop_comp_hw[CDBL_BIT];
			voltage_integ_cap_sel <= {loop_comp_hw[VIC_LO_MSB:VIC_LO_LSB],
				loop_comp_hw[VIC_HI_MSB:VIC_HI_LSB]};
			voltage_filter_cap_sel <= loop_comp_hw[VFC_MSB:VFC_LSB];
			voltage_gain_res_sel <= loop_comp_hw[VGR_MSB:VGR_LSB];
			voltage_transcond_sel <= loop_comp_hw[VTC_MSB:VTC_LSB];
			current_transcond_sel <= loop_comp_hw[CTC_MSB:CTC_LSB];
		end
	end

	// regulator select updates the cycle after the frame ends
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_sel_reg <= REG_SEL_RESET;
			regulator_voltage_sel <= REG_SEL_RESET;
		end else if (clk_en) begin
			if (state_reg == DS_RX && rx_last && cmd_reg == CMD_POWER_STAGE &&
				link.wdata[7:4] >= REG_SEL_MIN && link.wdata[7:4] <= REG_SEL_MAX) begin
				reg_sel_reg <= link.wdata[7:4];
			end
			regulator_voltage_sel <= reg_sel_reg;
		end
	end

	// sticky fault flag, a new fault wins over the clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			invalid_command_flag <= 1'b0;
		end else if (clk_en) begin
			if (ivc_event) begin
				invalid_command_flag <= 1'b1;
			end else if (clear_faults) begin
				invalid_command_flag <= 1'b0;
			end
		end
	end

	// status bytes and alert line follow the flag
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_byte <= 8'h00;
			status_comm <= 8'h00;
			link.alert_n <= 1'b1;
		end else if (clk_en) begin
			status_byte <= 8'h00;
			status_comm <= 8'h00;
			status_byte[STATUS_CML_BIT] <= invalid_command_flag;
			status_comm[INVALID_COMMAND_FLAG_BIT] <= invalid_command_flag;
			link.alert_n <= ~invalid_command_flag;
		end
	end
endmodule : pcr_device

// ### src/pcr_host.sv
/*
 * controller end: software registers start one frame at a time on the link and
 * collect read data; alert and completion raise a maskable interrupt.
 * assumes the device end answers every frame with done.
 */
`timescale 1ns/1ps
module pcr_host
	import pcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	pcr_link_if.host link,
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	output logic irq
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_SEND = 3'b010,
		HS_WAIT = 3'b100
	} pcr_hstate_t;

	pcr_hstate_t state_reg;
	logic [39:0] tx_reg;
	logic [39:0] rx_reg;
	logic [3:0] ps_reg;
	logic [2:0] cnt_reg;
	logic [IRQ_W-1:0] irq_stat_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic alert_seen_reg;
	logic go;

	assign go = wr_en && addr == A_CTRL && state_reg == HS_IDLE;

	// data staging registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tx_reg <= 40'h0000000000;
			ps_reg <= REG_SEL_RESET;
		end else if (clk_en && wr_en) begin
			if (addr == A_COMP_LO) begin
				tx_reg[31:0] <= wdata;
			end else if (addr == A_COMP_HI) begin
				tx_reg[39:32] <= wdata[7:0];
			end else if (addr == A_PS) begin
				ps_reg <= wdata[7:4];
			end
		end
	end

	// frame engine
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= HS_IDLE;
			cnt_reg <= 3'h0;
			rx_reg <= 40'h0000000000;
			link.start <= 1'b0;
			link.is_write <= 1'b0;
			link.cmd <= 8'h00;
			link.len <= 3'h0;
			link.wvalid <= 1'b0;
			link.wdata <= 8'h00;
			link.store_all <= 1'b0;
			link.restore_all <= 1'b0;
			link.clear_comp_override <= 1'b0;
		end else if (clk_en) begin
			link.start <= 1'b0;
			link.wvalid <= 1'b0;
			link.store_all <= 1'b0;
			link.restore_all <= 1'b0;
			link.clear_comp_override <= 1'b0;
			case (state_reg)
				HS_IDLE: begin
					if (go) begin
						cnt_reg <= 3'h0;
						rx_reg <= 40'h0000000000; // short reads must not show stale bytes
						link.start <= 1'b1;
						state_reg <= HS_WAIT;
						link.is_write <= 1'b0;
						if (wdata[2:0] == OP_RD_REV || wdata[2:0] == OP_WR_REV) begin
							link.cmd <= CMD_SILICON_REV;
							link.len <= LEN_SILICON_REV;
							link.is_write <= wdata[2:0] == OP_WR_REV;
							if (wdata[2:0] == OP_WR_REV) begin
								state_reg <= HS_SEND;
							end
						end else if (wdata[2:0] == OP_RD_COMP) begin
							link.cmd <= CMD_LOOP_COMP;
							link.len <= LEN_LOOP_COMP;
						end else if (wdata[2:0] == OP_WR_COMP) begin
							// five bytes, reserved bits forced zero
							link.cmd <= CMD_LOOP_COMP;
							link.len <= LEN_LOOP_COMP;
							link.is_write <= 1'b1;
							state_reg <= HS_SEND;
						end else if (wdata[2:0] == OP_RD_PS) begin
							link.cmd <= CMD_POWER_STAGE;
							link.len <= LEN_POWER_STAGE;
						end else if (wdata[2:0] == OP_WR_PS) begin
							// one byte still sent as block
							link.cmd <= CMD_POWER_STAGE;
							link.len <= LEN_POWER_STAGE;
							link.is_write <= 1'b1;
							state_reg <= HS_SEND;
						end else begin
							link.start <= 1'b0;
							link.store_all <= 1'b1;
							link.clear_comp_override <= 1'b1;
							link.restore_all <= 1'b1;
							state_reg <= HS_IDLE;
						end
					end
				end
				HS_SEND: begin
					link.wvalid <= 1'b1;
					cnt_reg <= cnt_reg + 3'h1;
					if (link.cmd == CMD_LOOP_COMP) begin
						link.wdata <= 8'((tx_reg & ~COMP_RSVD_MASK) >> {cnt_reg, 3'b000});
					end else begin
						link.wdata <= {(ps_reg == REG_SEL_MIN) ? REG_SEL_RESET : ps_reg, PS_RSVD_VAL};
					end
					if (cnt_reg + 3'h1 == link.len) begin
						state_reg <= HS_WAIT;
					end
				end
				HS_WAIT: begin
					// bytes land by count, so one and two byte reads stay right-aligned
					if (link.rvalid) begin
						rx_reg[{cnt_reg, 3'b000} +: 8] <= link.rdata;
						cnt_reg <= cnt_reg + 3'h1;
					end
					if (link.done) begin
						state_reg <= HS_IDLE;
					end
				end
				default: state_reg <= HS_IDLE;
			endcase
		end
	end

	// sticky interrupt status, set wins over write-one clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_stat_reg <= 2'b00;
			irq_mask_reg <= 2'b00;
			alert_seen_reg <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			alert_seen_reg <= ~link.alert_n;
			if (wr_en && addr == A_MASK) begin
				irq_mask_reg <= wdata[IRQ_W-1:0];
			end
			irq_stat_reg <= (irq_stat_reg & ~((wr_en && addr == A_IRQ) ? wdata[IRQ_W-1:0] : 2'b00))
				| {~link.alert_n && !alert_seen_reg, state_reg == HS_WAIT && link.done};
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// read port, data valid the cycle after the strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (clk_en) begin
			rdata <= 32'h00000000;
			if (rd_en) begin
				if (addr == A_COMP_LO) begin
					rdata <= tx_reg[31:0];
				end else if (addr == A_COMP_HI) begin
					rdata <= {24'h000000, tx_reg[39:32]};
				end else if (addr == A_PS) begin
					rdata <= {24'h000000, ps_reg, PS_RSVD_VAL};
				end else if (addr == A_RDATA_LO) begin
					rdata <= rx_reg[31:0];
				end else if (addr == A_RDATA_HI) begin
					rdata <= {24'h000000, rx_reg[39:32]};
				end else if (addr == A_STAT) begin
					rdata <= {29'h00000000, ~link.alert_n, state_reg == HS_IDLE, state_reg != HS_IDLE};
				end else if (addr == A_IRQ) begin
					rdata <= {30'h00000000, irq_stat_reg};
				end else if (addr == A_MASK) begin
					rdata <= {30'h00000000, irq_mask_reg};
				end
			end
		end
	end
endmodule : pcr_host

// ### dv/pcr_props.sv
/* link checker: frame shapes, byte order and fault notice between the two ends.
 assumes an instance beside the link interface, every port joined by name. */
`timescale 1ns/1ps
module pcr_props
	import pcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic is_write,
	input wire logic [7:0] cmd,
	input wire logic [2:0] len,
	input wire logic wvalid,
	input wire logic [7:0] wdata,
	input wire logic rvalid,
	input wire logic [7:0] rdata,
	input wire logic done,
	input wire logic alert_n,
	input wire logic store_all,
	input wire logic restore_all,
	input wire logic clear_comp_override
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// frame kinds told apart at the start strobe
	wire rd_rev = start && !is_write && cmd == CMD_SILICON_REV;
	wire wr_rev = start && is_write && cmd == CMD_SILICON_REV;
	wire rd_comp = start && !is_write && cmd == CMD_LOOP_COMP;
	wire wr_comp = start && is_write && cmd == CMD_LOOP_COMP;
	wire rd_ps = start && !is_write && cmd == CMD_POWER_STAGE;
	wire wr_ps = start && is_write && cmd == CMD_POWER_STAGE;
	a_rev_bytes: assert property (rd_rev |-> ##2 rvalid && rdata == REV_SUB_VAL
		##1 rvalid && done && rdata == {REV_MAJOR_VAL, REV_MINOR_VAL})
		else $error("revision read frame wrong");
	a_ro_alert: assert property (wr_rev |-> ##[1:4] !alert_n)
		else $error("no alert after read-only write");
	a_comp_write: assert property (wr_comp |-> len == LEN_LOOP_COMP ##1 wvalid [*5] ##1 done)
		else $error("compensation write frame wrong");
	a_comp_read: assert property (rd_comp |-> len == LEN_LOOP_COMP ##2 rvalid [*4]
		##1 rvalid && done)
		else $error("compensation read frame wrong");
	// reserved bits sit in byte 0 and bit 0 of byte 2
	a_comp_rsvd: assert property (wr_comp |-> ##1 (wdata & 8'hCC) == 8'h00 ##2 !wdata[0])
		else $error("reserved compensation bit sent as one");
	a_ps_write: assert property (wr_ps |-> len == LEN_POWER_STAGE
		##1 wvalid && wdata[7:4] != REG_SEL_MIN ##[1:3] done)
		else $error("power stage write frame wrong");
	a_ps_read: assert property (rd_ps |-> len == LEN_POWER_STAGE
		##2 rvalid && done && rdata[3:0] == PS_RSVD_VAL)
		else $error("power stage read frame wrong");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_apply_order: assert property (restore_all |-> store_all)
		else $error("restore without store");
	c_ro_write: cover property (wr_rev);
	c_comp_write: cover property (wr_comp ##1 wvalid);
	c_apply: cover property (restore_all && clear_comp_override);
endmodule : pcr_props

// ### dv/pmbus_config_registers_tb.sv
/* self-checking bench: both ends joined by the link, driven from the host register port.
 assumes the package constants and the hand-over timing of both ends. */
`timescale 1ns/1ps
module pmbus_config_registers_tb
	import pcr_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic conversion_en = 1'b0;
	logic clear_faults = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rdata;
	logic irq;
	logic [39:0] hw;
	logic [3:0] cic, vic, rsel;
	logic [4:0] cfc, vfc;
	logic [5:0] cgr, vgr;
	logic [1:0] vtc, ctc;
	logic cdbl;
	logic [7:0] sbyte, scomm;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	pcr_link_if link();
	pcr_device i_pcr_device (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link(link),
		.conversion_en(conversion_en), .clear_faults(clear_faults), .loop_comp_hw(hw),
		.current_integ_cap_sel(cic), .current_filter_cap_sel(cfc),
		.current_integ_cap_doubler(cdbl), .current_gain_res_sel(cgr),
		.voltage_integ_cap_sel(vic), .voltage_filter_cap_sel(vfc), .voltage_gain_res_sel(vgr),
		.voltage_transcond_sel(vtc), .current_transcond_sel(ctc),
		.regulator_voltage_sel(rsel), .status_byte(sbyte), .status_comm(scomm));
	pcr_host i_pcr_host (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link(link),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq));
	pcr_props i_pcr_props (.core_clk(core_clk), .rst(rst), .start(link.start),
		.is_write(link.is_write), .cmd(link.cmd), .len(link.len), .wvalid(link.wvalid),
		.wdata(link.wdata), .rvalid(link.rvalid), .rdata(link.rdata), .done(link.done),
		.alert_n(link.alert_n), .store_all(link.store_all), .restore_all(link.restore_all),
		.clear_comp_override(link.clear_comp_override));
	// 40 MHz clock
	initial forever #12.5 core_clk = ~core_clk;
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	// hang guard, far above the several hundred cycles the tests need
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// strobe drops one edge later, so back-to-back calls never collide
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask : rd
	// start one frame; apply has no frame, so it only waits
	task automatic op(input logic [2:0] c, input bit frame);
		int k;
		wr(A_CTRL, {29'h0, c});
		for (k = 0; k < 60 && frame; k++) begin
			@(posedge core_clk);
			#1;
			if (link.done === 1'b1) break;
		end
		if (k == 60) check(40'h0, 40'h1);
		repeat (4) @(posedge core_clk);
		#1;
	endtask : op
	task automatic end_test(input string s);
		$display("test %s finished", s);
	endtask : end_test
	task automatic wrcomp(input logic [39:0] w);
		wr(A_COMP_LO, w[31:0]);
		wr(A_COMP_HI, {24'h0, w[39:32]});
		op(OP_WR_COMP, 1'b1);
	endtask : wrcomp
	task automatic rdcomp(output logic [39:0] v);
		logic [31:0] lo, hi;
		op(OP_RD_COMP, 1'b1);
		rd(A_RDATA_LO, lo);
		rd(A_RDATA_HI, hi);
		v = {hi[7:0], lo};
	endtask : rdcomp
	function automatic logic [39:0] msk(input logic [39:0] w);
		return w & ~COMP_RSVD_MASK;
	endfunction : msk
	// field split of the compensation word, in the order of the field outputs
	function automatic logic [39:0] fld(input logic [39:0] w);
		return {5'h0, w[25:24], w[39:38], w[37:33], w[32], w[31:26], w[9:8], w[23:22],
			w[21:17], w[15:10], w[5:4], w[1:0]};
	endfunction : fld
	initial begin
		logic [31:0] d;
		logic [39:0] w, v, old;
		logic [3:0] cur;
		void'($urandom(32'h2F103B96));
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check(hw, COMP_RESET);
		check({36'h0, rsel}, {36'h0, REG_SEL_RESET});
		check({23'h0, sbyte, scomm, link.alert_n}, 40'h1);
		end_test("reset");
		// only the alert source may reach the interrupt line
		wr(A_MASK, 32'h2);
		op(OP_RD_REV, 1'b1);
		rd(A_RDATA_LO, d);
		check({8'h0, d}, {24'h0, REV_MAJOR_VAL, REV_MINOR_VAL, REV_SUB_VAL});
		check({39'h0, irq}, 40'h0);
		op(OP_WR_REV, 1'b1);
		check({38'h0, sbyte[STATUS_CML_BIT], scomm[INVALID_COMMAND_FLAG_BIT]}, 40'h3);
		check({38'h0, link.alert_n, irq}, 40'h1);
		// status shows the pending alert with the engine idle
		rd(A_STAT, d);
		check({8'h0, d}, 40'h6);
		op(OP_RD_REV, 1'b1);
		rd(A_RDATA_LO, d);
		check({8'h0, d}, {24'h0, REV_MAJOR_VAL, REV_MINOR_VAL, REV_SUB_VAL});
		@(posedge core_clk);
		clear_faults <= 1'b1;
		@(posedge core_clk);
		clear_faults <= 1'b0;
		wr(A_IRQ, 32'h3);
		repeat (2) @(posedge core_clk);
		#1;
		check({36'h0, sbyte[1], scomm[7], link.alert_n, irq}, 40'h2);
		rd(A_IRQ, d);
		check({8'h0, d}, 40'h0);
		rd(4'hF, d);
		check({8'h0, d}, 40'h0);
		// completion source alone reaches the line once unmasked
		wr(A_MASK, 32'h1);
		op(OP_RD_PS, 1'b1);
		check({39'h0, irq}, 40'h1);
		rd(A_IRQ, d);
		check({8'h0, d}, 40'h1);
		wr(A_IRQ, 32'h1);
		end_test("fault");
		// corners first, then random words while stopped
		for (int i = 0; i < 8; i++) begin
			w[31:0] = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $urandom();
			w[39:32] = (i == 0) ? 8'hFF : (i == 1) ? 8'h0 : 8'($urandom());
			wrcomp(w);
			check(hw, msk(w));
			check({5'h0, cic, cfc, cdbl, cgr, vic, vfc, vgr, vtc, ctc}, fld(msk(w)));
			rdcomp(v);
			check(v, msk(w));
		end
		end_test("compensation");
		// while converting the loop keeps the old word until the apply sequence
		old = msk(w);
		@(posedge core_clk);
		conversion_en <= 1'b1;
		w = {8'h5A, $urandom()};
		wrcomp(w);
		check(hw, old);
		rdcomp(v);
		check(v, msk(w));
		op(OP_APPLY, 1'b0);
		op(OP_APPLY, 1'b0);
		check(hw, msk(w));
		conversion_en <= 1'b0;
		end_test("blocked");
		// every code, valid and not; the host turns 3h into 9h
		cur = REG_SEL_RESET;
		for (int i = 0; i < 16; i++) begin
			wr(A_PS, {24'h0, 4'(i), 4'h0});
			op(OP_WR_PS, 1'b1);
			if (i == 3) cur = 4'h9;
			else if (i >= 4 && i <= 10) cur = 4'(i);
			check({36'h0, rsel}, {36'h0, cur});
			op(OP_RD_PS, 1'b1);
			rd(A_RDATA_LO, d);
			check({32'h0, d[7:0]}, {32'h0, cur, 4'h0});
		end
		end_test("power stage");
		// with the enable low a valid write must leave every register alone
		@(posedge core_clk);
		clk_en <= 1'b0;
		wr(A_PS, 32'h00000040);
		op(OP_WR_PS, 1'b0);
		check({36'h0, rsel}, {36'h0, cur});
		@(posedge core_clk);
		clk_en <= 1'b1;
		rd(A_PS, d);
		check({32'h0, d[7:0]}, 40'hF0);
		end_test("freeze");
		print_verdict();
	end
endmodule : pmbus_config_registers_tb
